// [hdl/field_status_violation_packer.sv]
// field status and first-violation packer for the non-safe input telegram
// assumes: beam stream and scan strobes come from logic on i_clk, beams in
// rotation order; telegram reader samples o_tlg_rd_data one cycle after address
`timescale 1ns/1ps
`default_nettype none

module field_status_violation_packer
  import fsv_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  // avalon-mm slave
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_irq,
  // scan engine
  input wire logic i_scan_start,
  input wire logic i_scan_end,
  input wire logic i_beam_valid,
  input wire logic signed [15:0] i_beam_angle,
  input wire logic [15:0] i_beam_dist,
  input wire logic [NUM_FIELDS-1:0] i_beam_hit,
  input wire logic i_func_b_active,
  input wire logic i_func_b_warn_seg1_free,
  input wire logic i_func_b_warn_seg2_free,
  input wire logic i_func_b_prot_seg1_free,
  input wire logic i_func_b_prot_seg2_free,
  input wire logic [3:0] i_func_b_pair_sel1,
  input wire logic [3:0] i_func_b_pair_sel2,
  input wire logic [3:0] i_func_b_pair_sel3,
  // telegram read port
  input wire logic [5:0] i_tlg_rd_addr,
  output logic [7:0] o_tlg_rd_data
);

  // ----------------------------------------------------------------
  // first interruption capture per field
  // ----------------------------------------------------------------
  // the first hit after scan start is kept; later beams of the scan are
  // ignored, so the stream must arrive in rotation order
  logic [NUM_FIELDS-1:0] seen_r;
  logic [NUM_FIELDS-1:0] seen_nxt;
  logic signed [15:0] cap_ang_r [NUM_FIELDS];
  logic [15:0] cap_dist_r [NUM_FIELDS];
  logic signed [15:0] pub_ang_r [NUM_FIELDS];
  logic [15:0] pub_dist_r [NUM_FIELDS];
  logic [NUM_FIELDS-1:0] first_hit;
  logic signed [15:0] ang_clamped;
  logic publish;
  logic ctrl_en_r;

  // angle outside the scan range is clamped, never wrapped
  assign ang_clamped = (i_beam_angle > ANGLE_MAX) ? ANGLE_MAX :
                       (i_beam_angle < ANGLE_MIN) ? ANGLE_MIN : i_beam_angle;
  assign publish = i_scan_end & ctrl_en_r;

  genvar g;
  generate
    for (g = 0; g < NUM_FIELDS; g++) begin : g_field
      localparam logic [15:0] DMAX = (g == F_A_PROT || g == F_B_PROT) ?
                                     PROT_DIST_MAX : WARN_DIST_MAX;
      logic [15:0] dist_clamped;
      assign dist_clamped = (i_beam_dist > DMAX) ? DMAX : i_beam_dist;
      assign first_hit[g] = i_beam_valid & i_beam_hit[g] & ~seen_r[g];
      assign seen_nxt[g] = seen_r[g] | first_hit[g];

      always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          cap_ang_r[g] <= 16'sh0000;
          cap_dist_r[g] <= 16'h0000;
        end else if (i_scan_start) begin
          cap_ang_r[g] <= 16'sh0000;
          cap_dist_r[g] <= 16'h0000;
        end else if (first_hit[g]) begin
          cap_ang_r[g] <= ang_clamped;
          cap_dist_r[g] <= dist_clamped;
        end
      end

      // a beam in the closing cycle still counts toward this scan
      always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          pub_ang_r[g] <= 16'sh0000;
          pub_dist_r[g] <= 16'h0000;
        end else if (publish) begin
          pub_ang_r[g] <= first_hit[g] ? ang_clamped : cap_ang_r[g];
          pub_dist_r[g] <= first_hit[g] ? dist_clamped : cap_dist_r[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      seen_r <= '0;
    end else if (i_scan_start) begin
      seen_r <= '0;
    end else begin
      seen_r <= seen_nxt;
    end
  end

  // ----------------------------------------------------------------
  // function b status
  // ----------------------------------------------------------------
  logic [7:0] predef_r;
  logic [7:0] st0_nxt;
  logic [7:0] st1_nxt;
  logic [7:0] st2_nxt;
  logic [7:0] st0_r;
  logic [7:0] st1_r;
  logic [7:0] st2_r;
  logic match1;
  logic match2;

  // a predefined pair of zero never matches, zero is no valid pair number
  assign match1 = (i_func_b_pair_sel1 == predef_r[3:0]) && (predef_r[3:0] != 4'h0);
  assign match2 = (i_func_b_pair_sel1 == predef_r[7:4]) && (predef_r[7:4] != 4'h0);
  assign st0_nxt = {1'b0,
                    i_func_b_prot_seg2_free, i_func_b_prot_seg1_free,
                    i_func_b_warn_seg2_free, i_func_b_warn_seg1_free,
                    ~seen_nxt[F_B_PROT], ~seen_nxt[F_B_WARN],
                    i_func_b_active};
  assign st1_nxt = {i_func_b_pair_sel2, i_func_b_pair_sel1};
  assign st2_nxt = {match2, match1, 2'b00, i_func_b_pair_sel3};

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st0_r <= 8'h00;
      st1_r <= 8'h00;
      st2_r <= 8'h00;
    end else if (publish) begin
      st0_r <= st0_nxt;
      st1_r <= st1_nxt;
      st2_r <= st2_nxt;
    end
  end

  // ----------------------------------------------------------------
  // telegram byte selection
  // ----------------------------------------------------------------
  // words go out high byte first
  logic [5:0] vio_off;
  logic [15:0] vio_word;
  logic in_a_vio;
  logic in_b_vio;
  logic [7:0] tlg_byte;

  assign in_a_vio = (i_tlg_rd_addr >= TLG_A_VIO_BYTE) && (i_tlg_rd_addr < TLG_B_VIO_BYTE);
  assign in_b_vio = (i_tlg_rd_addr >= TLG_B_VIO_BYTE) && (i_tlg_rd_addr <= TLG_LAST_BYTE);
  assign vio_off = i_tlg_rd_addr - (in_b_vio ? TLG_B_VIO_BYTE : TLG_A_VIO_BYTE);
  assign vio_word = vio_off[2] ?
                    (vio_off[1] ? pub_dist_r[{in_b_vio, 1'b1}] : pub_ang_r[{in_b_vio, 1'b1}]) :
                    (vio_off[1] ? pub_dist_r[{in_b_vio, 1'b0}] : pub_ang_r[{in_b_vio, 1'b0}]);
  assign tlg_byte = (i_tlg_rd_addr == TLG_B_STAT_BYTE) ? st0_r :
                    (i_tlg_rd_addr == TLG_B_STAT_BYTE + 6'h01) ? st1_r :
                    (i_tlg_rd_addr == TLG_B_STAT_BYTE + 6'h02) ? st2_r :
                    (in_a_vio | in_b_vio) ?
                    (vio_off[0] ? vio_word[7:0] : vio_word[15:8]) : 8'h00;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_tlg_rd_data <= 8'h00;
    end else begin
      o_tlg_rd_data <= tlg_byte;
    end
  end

  // ----------------------------------------------------------------
  // scan counter and interrupts
  // ----------------------------------------------------------------
  logic [31:0] scan_cnt_r;
  logic [NUM_IRQ-1:0] irq_stat_r;
  logic [NUM_IRQ-1:0] irq_stat_nxt;
  logic [NUM_IRQ-1:0] irq_mask_r;
  logic [NUM_IRQ-1:0] irq_set;
  logic [NUM_IRQ-1:0] irq_clr;
  logic wr_take;
  logic rd_take;
  logic sel_ctrl;
  logic sel_predef;
  logic sel_stat;
  logic sel_mask;
  logic sel_cnt;

  assign irq_set = {publish & seen_nxt[F_A_PROT], publish & seen_nxt[F_B_PROT], publish};
  assign irq_clr = (wr_take & sel_stat & i_avs_byteenable[0]) ?
                   i_avs_writedata[NUM_IRQ-1:0] : '0;
  // a new event wins over a clear in the same cycle
  assign irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_set;
  assign o_irq = |(irq_stat_r & irq_mask_r);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      irq_stat_r <= '0;
      scan_cnt_r <= 32'h0000_0000;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      scan_cnt_r <= publish ? scan_cnt_r + 32'h0000_0001 : scan_cnt_r;
    end
  end

  // ----------------------------------------------------------------
  // avalon-mm slave
  // ----------------------------------------------------------------
  // one wait state on every access keeps read data registered
  bus_state_t bus_r;
  logic [31:0] rd_mux;

  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & (bus_r != BUS_ACK);
  assign wr_take = i_avs_write & (bus_r == BUS_ACK);
  assign rd_take = i_avs_read & (bus_r == BUS_IDLE);
  assign sel_ctrl = (i_avs_address == REG_CTRL);
  assign sel_predef = (i_avs_address == REG_PREDEF);
  assign sel_stat = (i_avs_address == REG_IRQ_STAT);
  assign sel_mask = (i_avs_address == REG_IRQ_MASK);
  assign sel_cnt = (i_avs_address == REG_SCAN_CNT);
  // unmapped addresses read zero, writes to them are dropped
  assign rd_mux = sel_ctrl ? {31'h0, ctrl_en_r} :
                  sel_predef ? {24'h0, predef_r} :
                  sel_stat ? {29'h0, irq_stat_r} :
                  sel_mask ? {29'h0, irq_mask_r} :
                  sel_cnt ? scan_cnt_r : 32'h0;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bus_r <= BUS_IDLE;
    end else begin
      case (bus_r)
        BUS_IDLE: begin
          if (i_avs_read | i_avs_write) begin
            bus_r <= BUS_ACK;
          end
        end
        BUS_ACK: begin
          bus_r <= BUS_IDLE;
        end
        default: begin
          bus_r <= BUS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_avs_readdata <= 32'h0;
    end else if (rd_take) begin
      o_avs_readdata <= rd_mux;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_en_r <= CTRL_RST;
      predef_r <= PREDEF_RST;
      irq_mask_r <= IRQ_MASK_RST;
    end else if (wr_take & i_avs_byteenable[0]) begin
      ctrl_en_r <= sel_ctrl ? i_avs_writedata[0] : ctrl_en_r;
      predef_r <= sel_predef ? i_avs_writedata[7:0] : predef_r;
      irq_mask_r <= sel_mask ? i_avs_writedata[NUM_IRQ-1:0] : irq_mask_r;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_stat_place;
    @(posedge i_clk) disable iff (!i_arst_n)
      (i_tlg_rd_addr == TLG_B_STAT_BYTE) |=> (o_tlg_rd_data == $past(st0_r));
  endproperty
  a_stat_place: assert property (p_stat_place) else $error("status byte 0 misplaced");

  property p_prot_free;
    @(posedge i_clk) disable iff (!i_arst_n)
      publish |=> (st0_r[ST_PROT_FREE] == !$past(seen_nxt[F_B_PROT]))
                  && (st0_r[ST_ACTIVE] == $past(i_func_b_active));
  endproperty
  a_prot_free: assert property (p_prot_free) else $error("protective free flag wrong");

  property p_segs;
    @(posedge i_clk) disable iff (!i_arst_n)
      publish |=> (st0_r[ST_PSEG2:ST_WSEG1] == $past({i_func_b_prot_seg2_free,
                   i_func_b_prot_seg1_free, i_func_b_warn_seg2_free, i_func_b_warn_seg1_free}));
  endproperty
  a_segs: assert property (p_segs) else $error("segment flags wrong");

  property p_match;
    @(posedge i_clk) disable iff (!i_arst_n)
      publish ##1 (st2_r[ST_MATCH1] || st2_r[ST_MATCH2]) |->
        (st1_r[3:0] != 4'h0);
  endproperty
  a_match: assert property (p_match) else $error("match without a pair");

  property p_reserved;
    @(posedge i_clk) disable iff (!i_arst_n)
      !st0_r[7] && (st2_r[5:4] == 2'b00);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");

  property p_first_kept;
    @(posedge i_clk) disable iff (!i_arst_n)
      (seen_r[F_A_PROT] && !i_scan_start) |=> $stable(cap_ang_r[F_A_PROT]);
  endproperty
  a_first_kept: assert property (p_first_kept) else $error("later beam overwrote first");

  property p_prot_dist;
    @(posedge i_clk) disable iff (!i_arst_n)
      (pub_dist_r[F_A_PROT] <= PROT_DIST_MAX) && (pub_dist_r[F_B_PROT] <= PROT_DIST_MAX);
  endproperty
  a_prot_dist: assert property (p_prot_dist) else $error("protective distance over range");

  property p_warn_dist;
    @(posedge i_clk) disable iff (!i_arst_n)
      (pub_dist_r[F_A_WARN] <= WARN_DIST_MAX) && (pub_dist_r[F_B_WARN] <= WARN_DIST_MAX);
  endproperty
  a_warn_dist: assert property (p_warn_dist) else $error("warning distance over range");

  property p_angle;
    @(posedge i_clk) disable iff (!i_arst_n)
      (pub_ang_r[F_A_WARN] <= ANGLE_MAX) && (pub_ang_r[F_A_WARN] >= ANGLE_MIN)
      && (pub_ang_r[F_B_PROT] <= ANGLE_MAX) && (pub_ang_r[F_B_PROT] >= ANGLE_MIN);
  endproperty
  a_angle: assert property (p_angle) else $error("angle out of range");

  property p_b_vio_word;
    @(posedge i_clk) disable iff (!i_arst_n)
      (i_tlg_rd_addr == TLG_B_VIO_BYTE + 6'h03) |=>
        (o_tlg_rd_data == $past(pub_dist_r[F_B_PROT][7:0]));
  endproperty
  a_b_vio_word: assert property (p_b_vio_word) else $error("function b layout wrong");

  property p_a_vio_word;
    @(posedge i_clk) disable iff (!i_arst_n)
      (i_tlg_rd_addr == TLG_A_VIO_BYTE + 6'h04) |=>
        (o_tlg_rd_data == $past(pub_ang_r[F_A_WARN][15:8]));
  endproperty
  a_a_vio_word: assert property (p_a_vio_word) else $error("function a layout wrong");

  property p_together;
    @(posedge i_clk) disable iff (!i_arst_n)
      !publish |=> $stable(st0_r) && $stable(pub_ang_r[F_A_PROT]) && $stable(pub_dist_r[F_B_WARN]);
  endproperty
  a_together: assert property (p_together) else $error("telegram changed mid scan");

  property p_irq_set_wins;
    @(posedge i_clk) disable iff (!i_arst_n)
      publish |=> irq_stat_r[IRQ_SCAN] ##0 (o_irq || !irq_mask_r[IRQ_SCAN]);
  endproperty
  a_irq_set_wins: assert property (p_irq_set_wins) else $error("scan event lost");

  property p_wait_one;
    @(posedge i_clk) disable iff (!i_arst_n)
      (i_avs_read && o_avs_waitrequest) |=> (!o_avs_waitrequest || !i_avs_read);
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest held too long");

endmodule

`default_nettype wire

// [hdl/fsv_pkg.sv]
// constants and types of the field status and violation telegram packer
// assumes: one 20 MHz clock domain, scan engine on the same clock
//
// Function
// - function B status module occupies non-safe telegram bytes 17, 18 and 19.
// - byte 0 bit 0 active; bit 1 warning free; bit 2 protective free.
// - byte 0 bits 3-6 give warning and protective segment 1/2 free flags.
// - pair numbers 1-10 as nibbles: byte 1 low/high, byte 2 low.
// - byte 2 bits 6/7 set when active pair equals predefined pair 1/2.
// - report angle and distance of earliest interrupting beam in rotation order.
// - function A violation module at byte 20: four 16-bit words at 0,2,4,6.
// - protective violation angle is signed 16-bit, -135 to +135 degrees.
// - protective violation distance unsigned 16-bit mm, 0 to 8250.
// - warning violation distance unsigned 16-bit mm, 0 to 20000.
// - warning violation angle signed 16-bit at module byte 4, +-135 degrees.
// - function B violation module uses the function A four-word layout.

package fsv_pkg;

  // telegram byte positions
  localparam logic [5:0] TLG_B_STAT_BYTE = 6'h11;
  localparam logic [5:0] TLG_A_VIO_BYTE = 6'h14;
  localparam logic [5:0] TLG_B_VIO_BYTE = 6'h1c;
  localparam logic [5:0] TLG_LAST_BYTE = 6'h23;

  // status bit positions in module bytes 0 and 2
  localparam int ST_ACTIVE = 0;
  localparam int ST_WARN_FREE = 1;
  localparam int ST_PROT_FREE = 2;
  localparam int ST_WSEG1 = 3;
  localparam int ST_PSEG2 = 6;
  localparam int ST_MATCH1 = 6;
  localparam int ST_MATCH2 = 7;

  // value limits, angle in degrees, distance in mm
  localparam logic signed [15:0] ANGLE_MAX = 16'sh0087;
  localparam logic signed [15:0] ANGLE_MIN = -16'sh0087;
  localparam logic [15:0] PROT_DIST_MAX = 16'h203a;
  localparam logic [15:0] WARN_DIST_MAX = 16'h4e20;

  // field index: function A/B, protective/warning
  localparam int F_A_PROT = 0;
  localparam int F_A_WARN = 1;
  localparam int F_B_PROT = 2;
  localparam int F_B_WARN = 3;
  localparam int NUM_FIELDS = 4;

  // avalon register byte addresses
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_PREDEF = 5'h04;
  localparam logic [4:0] REG_IRQ_STAT = 5'h08;
  localparam logic [4:0] REG_IRQ_MASK = 5'h0c;
  localparam logic [4:0] REG_SCAN_CNT = 5'h10;

  // reset values
  localparam logic CTRL_RST = 1'b1;
  localparam logic [7:0] PREDEF_RST = 8'h21;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;

  // interrupt status bits
  localparam int IRQ_SCAN = 0;
  localparam int IRQ_B_PROT = 1;
  localparam int IRQ_A_PROT = 2;
  localparam int NUM_IRQ = 3;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } bus_state_t;

endpackage

// [verification/tb_top.sv]
// self-checking bench for the field status and violation packer
// assumes: telegram_reader keeps a fresh copy of bytes 17..35
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import fsv_pkg::*;
  logic clk, arst_n = 1'b0;
  logic [4:0] adr = 5'h00;
  logic rd = 1'b0, wr = 1'b0;
  logic [31:0] wdat = 32'h0, r;
  logic [3:0] be = 4'hf;
  wire logic [31:0] rdat;
  wire logic wreq, irq;
  logic st = 1'b0, en = 1'b0, bv = 1'b0, act = 1'b0;
  logic signed [15:0] ang = 16'sh0;
  logic [15:0] dst = 16'h0;
  logic [3:0] hit = 4'h0, seg = 4'h0, ps1 = 4'h0, ps2 = 4'h0, ps3 = 4'h0;
  wire logic [5:0] taddr;
  wire logic [7:0] tdat;
  logic [7:0] tb_bytes [0:35];
  int num_errors = 0, num_checks = 0, cyc = 0;
  // lowest angle as the raw telegram word, so it compares without sign extension
  localparam logic [15:0] ANG_LO = ANGLE_MIN;

  field_status_violation_packer dut (.i_clk(clk), .i_arst_n(arst_n), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(be),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .o_irq(irq), .i_scan_start(st),
    .i_scan_end(en), .i_beam_valid(bv), .i_beam_angle(ang), .i_beam_dist(dst),
    .i_beam_hit(hit), .i_func_b_active(act), .i_func_b_warn_seg1_free(seg[0]),
    .i_func_b_warn_seg2_free(seg[1]), .i_func_b_prot_seg1_free(seg[2]),
    .i_func_b_prot_seg2_free(seg[3]), .i_func_b_pair_sel1(ps1), .i_func_b_pair_sel2(ps2),
    .i_func_b_pair_sel3(ps3), .i_tlg_rd_addr(taddr), .o_tlg_rd_data(tdat));

  telegram_reader reader (.i_clk(clk), .i_arst_n(arst_n), .o_tlg_addr(taddr),
    .i_tlg_data(tdat), .o_tlg_bytes(tb_bytes));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [15:0] tw(input int i);
    return {tb_bytes[i], tb_bytes[i+1]};
  endfunction

  // waitrequest and read data are sampled at the rising edge, before it updates them
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     input logic [3:0] b);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wdat <= d;
    be <= b;
    rd <= !w;
    wr <= w;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 100);
    if (n >= 100) num_errors++;
    r = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic step(input logic s, input logic e, input logic [3:0] h,
                      input logic signed [15:0] a, input logic [15:0] d);
    @(posedge clk);
    st <= s;
    en <= e;
    bv <= (h != 4'h0);
    hit <= h;
    ang <= a;
    dst <= d;
  endtask

  task automatic settle;
    step(1'b0, 1'b0, 4'h0, 16'sh0, 16'h0);
    repeat (45) @(posedge clk);
    @(negedge clk);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    settle();
    for (int i = 17; i < 36; i++) chk(tb_bytes[i], 8'h00);
    bus(1'b0, REG_CTRL, 0, 4'hf); chk(r, 32'h1);
    bus(1'b0, REG_PREDEF, 0, 4'hf); chk(r, 32'h21);
    bus(1'b0, REG_IRQ_MASK, 0, 4'hf); chk(r, 32'h0);
    bus(1'b0, 5'h14, 0, 4'hf); chk(r, 32'h0);
    // scan 1: first hit per field wins, later hits ignored
    act <= 1'b1;
    seg <= 4'b1001;
    ps1 <= 4'h1;
    ps2 <= 4'h2;
    ps3 <= 4'ha;
    step(1'b1, 1'b0, 4'h0, 16'sh0, 16'h0);
    step(1'b0, 1'b0, 4'b0100, 16'sh000a, 16'h01f4);
    step(1'b0, 1'b0, 4'b1111, 16'shff00, 16'hffff);
    step(1'b0, 1'b1, 4'b1000, ANGLE_MAX, WARN_DIST_MAX);
    settle();
    chk(tb_bytes[17], 8'h49);
    chk(tb_bytes[18], 8'h21);
    chk(tb_bytes[19], 8'h4a);
    chk(tw(20), ANG_LO);
    chk(tw(22), PROT_DIST_MAX);
    chk(tw(24), ANG_LO);
    chk(tw(26), WARN_DIST_MAX);
    chk(tw(28), 16'h000a);
    chk(tw(30), 16'h01f4);
    chk(tw(32), ANG_LO);
    chk(tw(34), WARN_DIST_MAX);
    bus(1'b0, REG_IRQ_STAT, 0, 4'hf); chk(r, 32'h7);
    chk(irq, 1'b0);
    bus(1'b1, REG_IRQ_MASK, 32'h1, 4'he);
    bus(1'b0, REG_IRQ_MASK, 0, 4'hf); chk(r, 32'h0);
    bus(1'b1, REG_IRQ_MASK, 32'h1, 4'hf);
    @(negedge clk); chk(irq, 1'b1);
    bus(1'b1, REG_IRQ_STAT, 32'h1, 4'hf);
    @(negedge clk); chk(irq, 1'b0);
    bus(1'b0, REG_IRQ_STAT, 0, 4'hf); chk(r, 32'h6);
    bus(1'b1, REG_SCAN_CNT, 32'hff, 4'hf);
    bus(1'b0, REG_SCAN_CNT, 0, 4'hf); chk(r, 32'h1);
    // scan 2: only the closing-cycle hit on field A warning is accepted, beam in the start cycle must be dropped
    bus(1'b1, REG_IRQ_STAT, 32'h7, 4'hf);
    bus(1'b1, REG_PREDEF, 32'h35, 4'hf);
    act <= 1'b0;
    seg <= 4'hf;
    ps1 <= 4'h3;
    ps2 <= 4'h0;
    ps3 <= 4'h0;
    step(1'b1, 1'b0, 4'hf, 16'sh0032, 16'h0064);
    step(1'b0, 1'b1, 4'b0010, 16'sh0032, 16'h0064);
    settle();
    chk(tb_bytes[17], 8'h7e);
    chk(tb_bytes[18], 8'h03);
    chk(tb_bytes[19], 8'h80);
    for (int i = 20; i < 36; i += 2) chk(tw(i), (i == 24) ? 16'h0032 : (i == 26) ? 16'h0064 : 16'h0);
    chk(irq, 1'b1);
    bus(1'b0, REG_IRQ_STAT, 0, 4'hf); chk(r, 32'h1);
    // scan 3: publishing disabled, telegram must keep scan 2
    bus(1'b1, REG_IRQ_STAT, 32'h1, 4'hf);
    bus(1'b1, REG_CTRL, 32'h0, 4'hf);
    act <= 1'b1;
    step(1'b1, 1'b0, 4'h0, 16'sh0, 16'h0);
    step(1'b0, 1'b1, 4'hf, 16'sh0005, 16'h0007);
    settle();
    chk(tb_bytes[17], 8'h7e);
    chk(tw(20), 16'h0);
    chk(irq, 1'b0);
    bus(1'b0, REG_SCAN_CNT, 0, 4'hf); chk(r, 32'h2);
    stop_test();
  end
endmodule

`default_nettype wire

// [verification/telegram_reader.sv]
// fieldbus controller side: sweeps the telegram read port over bytes 17..35
// assumes: one byte of read latency, all on i_clk
`timescale 1ns/1ps
`default_nettype none

module telegram_reader
  import fsv_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  output logic [5:0] o_tlg_addr,
  input wire logic [7:0] i_tlg_data,
  output var logic [7:0] o_tlg_bytes [0:35]
);
  // ------------------------------------------------------------
  // address sweep and capture
  // ------------------------------------------------------------
  logic [5:0] prev_r;
  wire logic [5:0] addr_nxt = (o_tlg_addr == TLG_LAST_BYTE) ? TLG_B_STAT_BYTE :
                              o_tlg_addr + 6'h01;

  // data for an address lands two edges after that address was presented
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_tlg_addr <= TLG_B_STAT_BYTE;
      prev_r <= 6'h00;
    end else begin
      o_tlg_addr <= addr_nxt;
      prev_r <= o_tlg_addr;
      o_tlg_bytes[prev_r] <= i_tlg_data;
    end
  end
endmodule

`default_nettype wire
